// ===== cm_comm_config.sv
// protocol and baud selection, switch configuration session and comm lamps
//
// Notes on behaviour
// - default 9600 Modbus or 76800 BACnet, 8N1
// - 57600 and 115200 allowed only in Modbus
// - Ethernet link disables the serial port; baud writes are still taken
// - 1833 to 44612 in Modbus selects BACnet
// - 375 to 10190 in BACnet selects Modbus
// - all-zero switches at power-up force Modbus 9600
// - switches 999 at power-up start session
// - LSD 1 Modbus, 2 BACnet, lamps echo
// - MSD 1..6 picks baud, binary on lamps
// - ten second window from power-up
// - any switch change restarts the window
// - window expiry applies settings, switches address again
// - connecting flashes then solid green
// - failed connect flashes red then green
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cm_consts.svh"
module cm_comm_config import cm_pkg::*; #(
	parameter int WINDOW_CYC = `CM_WINDOW_CYC,
	parameter int BLINK_CYC = `CM_BLINK_CYC,
	parameter int DEB_CYC = `CM_DEB_CYC,
	parameter bit DEF_BACNET = 1'b0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// rotary address switches, least, middle and most significant digit
	input wire logic [3:0] sw_lsd,
	input wire logic [3:0] sw_mid,
	input wire logic [3:0] sw_msd,
	// serial port settings
	output logic proto_bacnet,
	output logic [2:0] baud_code,
	output logic [15:0] baud_div,
	output logic serial_en,
	output logic [3:0] data_bits,
	output logic parity_en,
	output logic [1:0] stop_bits,
	output logic [11:0] station_addr,
	output logic cfg_session,
	// lamps
	output logic serial_lamp_red,
	output logic comm_indicator_lamp_green,
	output logic comm_indicator_lamp_red,
	output logic phase_check_lamp_one,
	output logic phase_check_lamp_two,
	output logic phase_check_lamp_three
);
	localparam int TW = $clog2(WINDOW_CYC + 1);
	localparam int BW = $clog2(BLINK_CYC + 1);

	cm_state_t state_q;
	cm_proto_t proto_q;
	cm_proto_t sess_proto_q;
	cm_baud_t baud_q;
	cm_baud_t sess_baud_q;
	cm_lamp_t lamp_q;
	logic eth_q;
	logic [TW-1:0] timer_q;
	logic [BW-1:0] blink_cnt_q;
	logic [3:0] toggles_q;
	logic blink_ph_q;
	logic [31:0] prdata_q;
	logic [11:0] addr_q;
	logic [3:0] lsd;
	logic [3:0] mid;
	logic [3:0] msd;
	logic [2:0] settled;
	logic [2:0] changed;
	logic any_change;
	logic all_settled;
	logic access;
	logic wr;
	logic hit;
	logic cmd_to_bacnet;
	logic cmd_to_modbus;
	logic baud_ok;
	logic link_start;
	logic link_fail;
	logic window_done;
	logic lsd_valid;
	logic msd_valid;
	cm_baud_t wr_baud;
	cm_baud_t msd_baud;

	cm_debounce #(.W(4), .STABLE(DEB_CYC)) u_deb_lsd (.pclk(pclk), .presetn(presetn), .raw(sw_lsd),
		.clean_q(lsd), .settled_q(settled[0]), .changed_q(changed[0]));
	cm_debounce #(.W(4), .STABLE(DEB_CYC)) u_deb_mid (.pclk(pclk), .presetn(presetn), .raw(sw_mid),
		.clean_q(mid), .settled_q(settled[1]), .changed_q(changed[1]));
	cm_debounce #(.W(4), .STABLE(DEB_CYC)) u_deb_msd (.pclk(pclk), .presetn(presetn), .raw(sw_msd),
		.clean_q(msd), .settled_q(settled[2]), .changed_q(changed[2]));

	assign any_change = |changed;
	assign all_settled = &settled;

	function automatic logic [15:0] div_of(cm_baud_t b);
		int rate;
		case (b)
			CM_B9600: rate = 9600;
			CM_B19200: rate = 19200;
			CM_B38400: rate = 38400;
			CM_B57600: rate = 57600;
			CM_B76800: rate = 76800;
			CM_B115200: rate = 115200;
			default: rate = 9600;
		endcase
		return 16'(`CM_CLK_HZ / rate);
	endfunction

	function automatic logic modbus_only(cm_baud_t b);
		return (b == CM_B57600) || (b == CM_B115200);
	endfunction

	// apb decode; the slave never inserts wait states
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign hit = (paddr == `CM_OFF_CTRL) || (paddr == `CM_OFF_STATUS) || (paddr == `CM_OFF_CMD)
		|| (paddr == `CM_OFF_BAUD) || (paddr == `CM_OFF_LINK) || (paddr == `CM_OFF_ADDR);
	assign pready = 1'b1;
	assign pslverr = access && !hit;
	assign prdata = prdata_q;

	// protocol commands are refused while the switch session owns the settings
	assign cmd_to_bacnet = wr && (paddr == `CM_OFF_CMD) && (state_q == ST_RUN) && (proto_q == CM_MODBUS)
		&& (pwdata[31:16] == `CM_HOLD_PROTO) && (pwdata[15:0] == `CM_VAL_TO_BACNET);
	assign cmd_to_modbus = wr && (paddr == `CM_OFF_CMD) && (state_q == ST_RUN) && (proto_q == CM_BACNET)
		&& (pwdata[31:16] == `CM_OBJ_PROTO) && (pwdata[15:0] == `CM_VAL_TO_MODBUS);
	assign wr_baud = cm_baud_t'(pwdata[2:0]);
	assign baud_ok = (pwdata[2:0] <= 3'(CM_B115200)) && !(proto_q == CM_BACNET && modbus_only(wr_baud));
	assign link_fail = wr && (paddr == `CM_OFF_LINK) && pwdata[`CM_LINK_FAIL_BIT];
	assign link_start = wr && (paddr == `CM_OFF_LINK) && pwdata[`CM_LINK_START_BIT] && !link_fail;

	assign lsd_valid = (lsd == `CM_LSD_MODBUS) || (lsd == `CM_LSD_BACNET);
	assign msd_valid = (msd != `CM_DIGIT_ZERO) && (msd <= `CM_MSD_MAX);
	assign msd_baud = cm_baud_t'(msd[2:0] - 3'h1);
	assign window_done = (timer_q == TW'(WINDOW_CYC - 1)) && !any_change;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`CM_OFF_CTRL: prdata_q <= {31'h0, eth_q};
				`CM_OFF_STATUS: prdata_q <= {26'h0, eth_q, cfg_session, baud_q, proto_q};
				`CM_OFF_BAUD: prdata_q <= {29'h0, baud_q};
				`CM_OFF_ADDR: prdata_q <= {20'h0, addr_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eth_q <= 1'b0;
		end else if (wr && paddr == `CM_OFF_CTRL) begin
			eth_q <= pwdata[`CM_CTRL_ETH_BIT];
		end
	end

	// mode sequencer: boot check of the switches, session, normal running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_BOOT;
			proto_q <= DEF_BACNET ? CM_BACNET : CM_MODBUS;
			baud_q <= DEF_BACNET ? CM_B76800 : CM_B9600;
			sess_proto_q <= CM_MODBUS;
			sess_baud_q <= CM_B9600;
			timer_q <= '0;
		end else begin
			case (state_q)
				ST_BOOT: begin
					if (all_settled) begin
						sess_proto_q <= proto_q;
						sess_baud_q <= baud_q;
						timer_q <= '0;
						if (lsd == `CM_DIGIT_CFG && mid == `CM_DIGIT_CFG && msd == `CM_DIGIT_CFG) begin
							state_q <= ST_SESSION;
						end else begin
							state_q <= ST_RUN;
							if (lsd == `CM_DIGIT_ZERO && mid == `CM_DIGIT_ZERO && msd == `CM_DIGIT_ZERO) begin
								proto_q <= CM_MODBUS;
								baud_q <= CM_B9600;
							end
						end
					end
				end
				ST_SESSION: begin
					if (any_change) begin
						timer_q <= '0;
					end else if (!window_done) begin
						timer_q <= timer_q + TW'(1);
					end
					if (lsd == `CM_LSD_MODBUS) begin
						sess_proto_q <= CM_MODBUS;
					end else if (lsd == `CM_LSD_BACNET) begin
						sess_proto_q <= CM_BACNET;
					end
					if (msd_valid) begin
						sess_baud_q <= msd_baud;
					end
					if (window_done) begin
						state_q <= ST_RUN;
						proto_q <= sess_proto_q;
						// a Modbus-only rate picked for BACnet falls back to the BACnet default
						if (sess_proto_q == CM_BACNET && modbus_only(sess_baud_q)) begin
							baud_q <= CM_B76800;
						end else begin
							baud_q <= sess_baud_q;
						end
					end
				end
				ST_RUN: begin
					if (cmd_to_bacnet) begin
						proto_q <= CM_BACNET;
						baud_q <= CM_B76800;
					end else if (cmd_to_modbus) begin
						proto_q <= CM_MODBUS;
						baud_q <= CM_B9600;
					end else if (wr && paddr == `CM_OFF_BAUD && baud_ok) begin
						baud_q <= wr_baud;
					end
				end
				default: state_q <= ST_BOOT;
			endcase
		end
	end

	// switches act as station address only outside the session
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= 12'h000;
		end else if (state_q == ST_RUN) begin
			addr_q <= {msd, mid, lsd};
		end
	end

	// comm lamp sequencer: a short burst of blinks, then solid green
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lamp_q <= LAMP_OFF;
			blink_cnt_q <= '0;
			toggles_q <= 4'h0;
			blink_ph_q <= 1'b0;
		end else if (state_q == ST_RUN && (link_fail || link_start)) begin
			lamp_q <= link_fail ? LAMP_FAILING : LAMP_CONNECTING;
			blink_cnt_q <= '0;
			toggles_q <= 4'h0;
			blink_ph_q <= 1'b1;
		end else if (lamp_q == LAMP_CONNECTING || lamp_q == LAMP_FAILING) begin
			if (blink_cnt_q == BW'(BLINK_CYC - 1)) begin
				blink_cnt_q <= '0;
				blink_ph_q <= !blink_ph_q;
				toggles_q <= toggles_q + 4'h1;
				if (toggles_q == `CM_BLINK_TOGGLES - 4'h1) begin
					lamp_q <= LAMP_SOLID;
				end
			end else begin
				blink_cnt_q <= blink_cnt_q + BW'(1);
			end
		end
	end

	// lamp outputs; the session echo overrides normal indication
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_lamp_red <= 1'b0;
			comm_indicator_lamp_green <= 1'b0;
			comm_indicator_lamp_red <= 1'b0;
			phase_check_lamp_one <= 1'b0;
			phase_check_lamp_two <= 1'b0;
			phase_check_lamp_three <= 1'b0;
		end else if (state_q == ST_SESSION) begin
			serial_lamp_red <= lsd_valid;
			comm_indicator_lamp_red <= (lsd == `CM_LSD_BACNET);
			comm_indicator_lamp_green <= 1'b0;
			phase_check_lamp_one <= msd_valid && msd[2];
			phase_check_lamp_two <= msd_valid && msd[1];
			phase_check_lamp_three <= msd_valid && msd[0];
		end else begin
			serial_lamp_red <= 1'b0;
			phase_check_lamp_one <= 1'b0;
			phase_check_lamp_two <= 1'b0;
			phase_check_lamp_three <= 1'b0;
			comm_indicator_lamp_red <= (lamp_q == LAMP_FAILING) && blink_ph_q;
			comm_indicator_lamp_green <= (lamp_q == LAMP_SOLID)
				|| ((lamp_q == LAMP_CONNECTING) && blink_ph_q);
		end
	end

	assign proto_bacnet = (proto_q == CM_BACNET);
	assign baud_code = baud_q;
	assign baud_div = div_of(baud_q);
	assign serial_en = !eth_q;
	assign data_bits = `CM_DATA_BITS;
	assign parity_en = 1'b0;
	assign stop_bits = `CM_STOP_BITS;
	assign station_addr = addr_q;
	assign cfg_session = (state_q == ST_SESSION);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_boot_zero;
		state_q == ST_BOOT && all_settled && lsd == 4'h0 && mid == 4'h0 && msd == 4'h0;
	endsequence
	sequence s_boot_cfg;
		state_q == ST_BOOT && all_settled && lsd == 4'h9 && mid == 4'h9 && msd == 4'h9;
	endsequence

	a_boot_default_rate: assert property (state_q == ST_BOOT |-> baud_q == (DEF_BACNET ? CM_B76800 : CM_B9600))
		else $error("boot baud is not the protocol default");
	a_bacnet_rate_legal: assert property (proto_q == CM_BACNET |-> !modbus_only(baud_q))
		else $error("BACnet running at a Modbus-only rate");
	a_eth_serial_off: assert property (wr && paddr == `CM_OFF_CTRL && pwdata[0] |=> !serial_en)
		else $error("serial port still enabled after Ethernet select");
	a_cmd_to_bacnet: assert property (cmd_to_bacnet |=> proto_bacnet && baud_code == 3'h4)
		else $error("BACnet switch command not applied");
	a_cmd_to_modbus: assert property (cmd_to_modbus |=> !proto_bacnet && baud_code == 3'h0)
		else $error("Modbus switch command not applied");
	a_failsafe_zero: assert property (s_boot_zero |=> !proto_bacnet && baud_code == 3'h0 && state_q == ST_RUN)
		else $error("all-zero switches did not force Modbus 9600");
	a_session_entry: assert property (s_boot_cfg |=> cfg_session)
		else $error("999 at power-up did not open the session");
	a_bacnet_echo: assert property (cfg_session && lsd == 4'h2 |=> serial_lamp_red && comm_indicator_lamp_red)
		else $error("BACnet selection not echoed on the lamps");
	a_phase_code: assert property (cfg_session && msd == 4'h5 ##1 cfg_session |->
		phase_check_lamp_one && !phase_check_lamp_two && phase_check_lamp_three)
		else $error("baud code 5 not shown on the phase lamps");
	a_window_restart: assert property (cfg_session && any_change |=> timer_q == '0)
		else $error("switch change did not restart the window");
	a_window_apply: assert property (cfg_session && window_done |=>
		state_q == ST_RUN && proto_q == $past(sess_proto_q))
		else $error("window expiry did not apply the session protocol");
	a_fail_flash: assert property (state_q == ST_RUN && link_fail |=>
		lamp_q == LAMP_FAILING ##1 comm_indicator_lamp_red)
		else $error("failed connect did not flash red");
	a_bad_digit_dark: assert property (cfg_session && !msd_valid ##1 cfg_session |->
		!phase_check_lamp_one && !phase_check_lamp_two && !phase_check_lamp_three)
		else $error("unlisted baud digit lit a phase lamp");
endmodule
`default_nettype wire

// ===== cm_consts.svh
// constants for the communication mode and baud configuration block
`ifndef CM_CONSTS_SVH
`define CM_CONSTS_SVH
`define CM_CLK_HZ 40000000
`define CM_CLK_KHZ 40000
`define CM_WINDOW_MS 10000
`define CM_WINDOW_CYC (`CM_WINDOW_MS * `CM_CLK_KHZ)
`define CM_BLINK_MS 100
`define CM_BLINK_CYC (`CM_BLINK_MS * `CM_CLK_KHZ)
`define CM_BLINK_TOGGLES 4'h6
`define CM_DEB_MS 5
`define CM_DEB_CYC (`CM_DEB_MS * `CM_CLK_KHZ)
`define CM_OFF_CTRL 12'h000
`define CM_OFF_STATUS 12'h004
`define CM_OFF_CMD 12'h008
`define CM_OFF_BAUD 12'h00c
`define CM_OFF_LINK 12'h010
`define CM_OFF_ADDR 12'h014
`define CM_HOLD_PROTO 16'hae44
`define CM_VAL_TO_BACNET 16'h0729
`define CM_OBJ_PROTO 16'h27ce
`define CM_VAL_TO_MODBUS 16'h0177
`define CM_DIGIT_CFG 4'h9
`define CM_DIGIT_ZERO 4'h0
`define CM_LSD_MODBUS 4'h1
`define CM_LSD_BACNET 4'h2
`define CM_MSD_MAX 4'h6
`define CM_DATA_BITS 4'h8
`define CM_STOP_BITS 2'h1
`define CM_CTRL_ETH_BIT 0
`define CM_LINK_START_BIT 0
`define CM_LINK_FAIL_BIT 1
`define CM_ST_SESSION_BIT 4
`define CM_ST_ETH_BIT 5
`endif

// ===== cm_pkg.sv
// types for the communication mode and baud configuration block
package cm_pkg;
	typedef enum logic [2:0] {CM_B9600, CM_B19200, CM_B38400, CM_B57600, CM_B76800, CM_B115200} cm_baud_t;
	typedef enum logic {CM_MODBUS, CM_BACNET} cm_proto_t;
	typedef enum logic [1:0] {ST_BOOT, ST_SESSION, ST_RUN} cm_state_t;
	typedef enum logic [1:0] {LAMP_OFF, LAMP_CONNECTING, LAMP_SOLID, LAMP_FAILING} cm_lamp_t;
endpackage

// ===== cm_debounce.sv
// synchroniser and debouncer for one rotary switch digit
`timescale 1ns/1ps
`default_nettype none
`include "cm_consts.svh"
module cm_debounce #(
	parameter int W = 4,
	parameter int STABLE = `CM_DEB_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// switch pins and cleaned result
	input wire logic [W-1:0] raw,
	output logic [W-1:0] clean_q,
	output logic settled_q,
	output logic changed_q
);
	localparam int CW = $clog2(STABLE + 1);
	logic [W-1:0] sync1_q;
	logic [W-1:0] sync2_q;
	logic [W-1:0] cand_q;
	logic [CW-1:0] cnt_q;
	logic stable;

	assign stable = (cnt_q == CW'(STABLE - 1)) && (sync2_q == cand_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
		end
	end

	// any bounce restarts the stability count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cand_q <= '0;
			cnt_q <= '0;
		end else if (sync2_q != cand_q) begin
			cand_q <= sync2_q;
			cnt_q <= '0;
		end else if (cnt_q != CW'(STABLE - 1)) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clean_q <= '0;
			settled_q <= 1'b0;
			changed_q <= 1'b0;
		end else begin
			changed_q <= stable && settled_q && (clean_q != cand_q);
			if (stable) begin
				clean_q <= cand_q;
				settled_q <= 1'b1;
			end
		end
	end

	a_change_needs_stable: assert property (@(posedge pclk) disable iff (!presetn)
		changed_q |-> $past(cnt_q) == CW'(STABLE - 1))
		else $error("switch change reported before the position was stable");
endmodule
`default_nettype wire

// ===== cm_host_model.sv
// serial host model: tells whether its frames would reach the device
`timescale 1ns/1ps
`default_nettype none
module cm_host_model import cm_pkg::*; (
	// device serial settings
	input wire logic [2:0] baud_code,
	input wire logic serial_en,
	input wire logic [11:0] station_addr,
	// host own settings and verdict
	input wire logic [31:0] host_rate,
	input wire logic [11:0] host_addr,
	output logic reached
);
	logic [31:0] dev_rate;
	always_comb begin
		case (baud_code)
			3'h0: dev_rate = 32'h2580;
			3'h1: dev_rate = 32'h4b00;
			3'h2: dev_rate = 32'h9600;
			3'h3: dev_rate = 32'he100;
			3'h4: dev_rate = 32'h12c00;
			3'h5: dev_rate = 32'h1c200;
			default: dev_rate = 32'h0;
		endcase
	end
	// a host with a wrong rate or address is simply never answered
	assign reached = serial_en && (host_rate == dev_rate) && (host_addr == station_addr);
endmodule
`default_nettype wire

// ===== comm_mode_baud_config_bench.sv
// self-checking bench for the protocol and baud configuration block
`timescale 1ns/1ps
`default_nettype none
module comm_mode_baud_config_bench;
	import cm_pkg::*;
	localparam int WIN = 200;
	localparam int DEB = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, reached;
	logic [11:0] paddr, station_addr, host_addr;
	logic [31:0] pwdata, prdata, rd, host_rate;
	logic [3:0] sw_lsd, sw_mid, sw_msd, data_bits;
	logic proto_bacnet, serial_en, parity_en, cfg_session;
	logic [2:0] baud_code;
	logic [15:0] baud_div;
	logic [1:0] stop_bits;
	logic lred, cgreen, cred, ph1, ph2, ph3;
	logic [31:0] rate_tab [6];
	int fails, cmp_count, lows, reds;

	cm_comm_config #(.WINDOW_CYC(WIN), .BLINK_CYC(4), .DEB_CYC(DEB), .DEF_BACNET(1'b0)) i_cm_comm_config (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sw_lsd(sw_lsd), .sw_mid(sw_mid), .sw_msd(sw_msd), .proto_bacnet(proto_bacnet),
		.baud_code(baud_code), .baud_div(baud_div), .serial_en(serial_en), .data_bits(data_bits),
		.parity_en(parity_en), .stop_bits(stop_bits), .station_addr(station_addr),
		.cfg_session(cfg_session), .serial_lamp_red(lred), .comm_indicator_lamp_green(cgreen),
		.comm_indicator_lamp_red(cred), .phase_check_lamp_one(ph1), .phase_check_lamp_two(ph2),
		.phase_check_lamp_three(ph3));
	cm_host_model i_cm_host_model (.baud_code(baud_code), .serial_en(serial_en),
		.station_addr(station_addr), .host_rate(host_rate), .host_addr(host_addr), .reached(reached));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer: setup, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk_cfg(input logic p, input int c);
		cyc(1);
		chk({31'h0, proto_bacnet}, {31'h0, p});
		chk({29'h0, baud_code}, c);
		chk({16'h0, baud_div}, 32'h2625a00 / rate_tab[c]);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd & 32'h0f, {28'h0, c[2:0], p});
	endtask

	task automatic set_sw(input logic [11:0] sw);
		{sw_msd, sw_mid, sw_lsd} <= sw;
		cyc(DEB + 6);
	endtask

	task automatic do_reset(input logic [11:0] sw);
		presetn <= 1'b0;
		{sw_msd, sw_mid, sw_lsd} <= sw;
		cyc(10);
		presetn <= 1'b1;
		cyc(DEB + 12);
	endtask

	task automatic wait_sess(input logic v, input int n);
		int k;
		k = 0;
		while (cfg_session !== v && k < n) begin
			@(posedge pclk);
			k++;
		end
		chk({31'h0, cfg_session}, {31'h0, v});
	endtask

	task automatic lamp_seq(input logic [31:0] cmd);
		apb(1'b1, 12'h010, cmd);
		lows = 0;
		reds = 0;
		repeat (50) begin
			@(posedge pclk);
			lows += (cgreen === 1'b0);
			reds += (cred === 1'b1);
		end
		chk({30'h0, cgreen, cred}, 32'h2);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		// watchdog at 20000 cycles, far above the whole test plan of some 1300 cycles
		repeat (20000) @(posedge pclk);
		fails++;
		$display("watchdog expired");
		summarize();
	end

	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		{sw_msd, sw_mid, sw_lsd} = 12'h000;
		host_rate = 32'h2580;
		host_addr = 12'h000;
		fails = 0;
		cmp_count = 0;
		rate_tab = '{32'h2580, 32'h4b00, 32'h9600, 32'he100, 32'h12c00, 32'h1c200};
		do_reset(12'h000);
		chk_cfg(1'b0, 0);
		chk({25'h0, data_bits, parity_en, stop_bits}, {25'h0, 4'h8, 1'b0, 2'h1});
		chk({31'h0, reached}, 32'h1);
		host_addr <= 12'h001;
		cyc(1);
		chk({31'h0, reached}, 32'h0);
		host_addr <= 12'h000;
		$display("test failsafe done");
		apb(1'b1, 12'h00c, 32'h5);
		chk_cfg(1'b0, 5);
		chk({31'h0, reached}, 32'h0);
		apb(1'b1, 12'h008, 32'hae44_0728);
		chk_cfg(1'b0, 5);
		apb(1'b1, 12'h008, 32'hae44_0729);
		chk_cfg(1'b1, 4);
		apb(1'b1, 12'h00c, 32'h3);
		chk_cfg(1'b1, 4);
		apb(1'b1, 12'h00c, 32'h5);
		chk_cfg(1'b1, 4);
		apb(1'b1, 12'h00c, 32'h1);
		chk_cfg(1'b1, 1);
		apb(1'b1, 12'h008, 32'hae44_0729);
		chk_cfg(1'b1, 1);
		apb(1'b1, 12'h008, 32'h27ce_0177);
		chk_cfg(1'b0, 0);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, 12'h00c, i);
			chk_cfg(1'b0, i);
		end
		apb(1'b1, 12'h00c, 32'h6);
		chk_cfg(1'b0, 5);
		$display("test protocol writes done");
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk({31'h0, serial_en}, 32'h0);
		chk(rd & 32'h20, 32'h20);
		apb(1'b1, 12'h000, 32'h0);
		cyc(1);
		chk({31'h0, serial_en}, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		$display("test link and bus done");
		lamp_seq(32'h1);
		lamp_seq(32'h1);
		chk({31'h0, lows > 0 && reds == 0}, 32'h1);
		lamp_seq(32'h3);
		chk({31'h0, reds > 0}, 32'h1);
		$display("test lamps done");
		do_reset(12'h999);
		wait_sess(1'b1, 20);
		chk({26'h0, lred, cred, ph1, ph2, ph3, 1'b0}, 32'h0);
		set_sw(12'h992);
		chk({30'h0, lred, cred}, 32'h3);
		set_sw(12'h591);
		chk({27'h0, lred, cred, ph1, ph2, ph3}, 32'h15);
		for (int m = 1; m < 7; m++) begin
			set_sw({m[3:0], 8'h92});
			chk({29'h0, ph1, ph2, ph3}, m);
		end
		set_sw(12'h792);
		chk({29'h0, ph1, ph2, ph3}, 32'h0);
		set_sw(12'h592);
		sw_msd <= 4'h3;
		cyc(2);
		sw_msd <= 4'h5;
		cyc(3);
		chk({29'h0, ph1, ph2, ph3}, 32'h5);
		cyc(DEB + 3);
		chk({29'h0, ph1, ph2, ph3}, 32'h5);
		cyc(150);
		set_sw(12'h582);
		cyc(150);
		chk({31'h0, cfg_session}, 32'h1);
		wait_sess(1'b0, 100);
		chk_cfg(1'b1, 4);
		cyc(2);
		chk({20'h0, station_addr}, 32'h582);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h582);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h4);
		$display("test switch session done");
		do_reset(12'h999);
		wait_sess(1'b1, 20);
		cyc(WIN - 20);
		chk({31'h0, cfg_session}, 32'h1);
		wait_sess(1'b0, 40);
		chk_cfg(1'b0, 0);
		$display("test session window done");
		do_reset(12'h999);
		wait_sess(1'b1, 20);
		set_sw(12'h692);
		chk({27'h0, lred, cred, ph1, ph2, ph3}, 32'h1e);
		wait_sess(1'b0, WIN + 20);
		chk_cfg(1'b1, 4);
		$display("test session fallback done");
		summarize();
	end
endmodule
`default_nettype wire
